//--- core/ipm_map.vh
// constants for the interrupt priority and power mode controller
`ifndef IPM_MAP_VH
`define IPM_MAP_VH
// number of sources and width of the priority field
`define IPM_NSRC 10
`define IPM_PRIO_W 2
// source index in polling order
`define IPM_IDX_EXT0 4'h0
`define IPM_IDX_BO 4'h1
`define IPM_IDX_T0 4'h2
`define IPM_IDX_EXT1 4'h3
`define IPM_IDX_T1 4'h4
`define IPM_IDX_CA 4'h5
`define IPM_IDX_EXT2 4'h6
`define IPM_IDX_EXT3 4'h7
`define IPM_IDX_SER 4'h8
`define IPM_IDX_T2 4'h9
// vector addresses
`define IPM_VEC_EXT0 16'h0003
`define IPM_VEC_BO 16'h004B
`define IPM_VEC_T0 16'h000B
`define IPM_VEC_EXT1 16'h0013
`define IPM_VEC_T1 16'h001B
`define IPM_VEC_CA 16'h0033
`define IPM_VEC_EXT2 16'h003B
`define IPM_VEC_EXT3 16'h0043
`define IPM_VEC_SER 16'h0023
`define IPM_VEC_T2 16'h002B
// power control register fields and values
`define IPM_POWER_CONTROL_REGISTER_IDLE_BIT 0
`define IPM_POWER_CONTROL_REGISTER_PD_BIT 1
`define IPM_POWER_CONTROL_REGISTER_IDLE_VAL 8'h01
`define IPM_POWER_CONTROL_REGISTER_PD_VAL 8'h02
// extended enable register address and brown-out enable bit
`define IPM_IEA_ADDR 8'hE8
`define IPM_IEA_BO_BIT 3
// oscillator clocks per machine cycle
`define IPM_MC_NORMAL 4'hC
`define IPM_MC_DOUBLE 4'h6
// least low time of a wake pin, oscillator clocks
`define IPM_WAKE_LOW_MIN 1024
`endif

//--- core/ipm_mcycle.v
// machine cycle divider, twelve or six oscillator clocks per cycle
`timescale 1ns/1ps
`default_nettype none
module ipm_mcycle (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire div_sel,
  output wire tick
);
  `include "ipm_map.vh"
  reg [3:0] cnt_reg;
  reg tick_reg;
  wire [3:0] last;
  assign last = div_sel ? (`IPM_MC_DOUBLE - 4'h1) : (`IPM_MC_NORMAL - 4'h1);
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
    end
    else if (!run)
      tick_reg <= 1'b0;
    else if (cnt_reg >= last)
    begin
      cnt_reg <= 4'h0;
      tick_reg <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 4'h1;
      tick_reg <= 1'b0;
    end
  end
  assign tick = tick_reg;
endmodule // ipm_mcycle
`default_nettype wire

//--- core/ipm_sync.v
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ipm_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  reg [W-1:0] q_reg;
  integer i;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1)
        if (s2_reg[i] == s3_reg[i])
          q_reg[i] <= s3_reg[i];
    end
  end
  assign q = q_reg;
endmodule // ipm_sync
`default_nettype wire

//--- core/ipm_top.v
// interrupt priority arbiter with idle, power-down and clock doubling control
`timescale 1ns/1ps
`default_nettype none
module ipm_top (
  input wire clk,
  input wire rst_n,
  input wire ext_int0_n,
  input wire ext_int1_n,
  input wire internal_memory_select_pin,
  input wire [1:0] ext_edge_sel,
  input wire brownout_event,
  input wire timer0_flag,
  input wire timer1_flag,
  input wire counter_array_flag,
  input wire ext2_flag,
  input wire ext3_flag,
  input wire [2:0] serial_spi_flags,
  input wire timer2_flag,
  input wire global_enable,
  input wire [9:0] irq_enable,
  input wire [7:0] extended_irq_enable_register,
  input wire [19:0] irq_priority,
  input wire power_control_wr,
  input wire [7:0] power_control_wdata,
  input wire core_ack,
  input wire core_reti,
  input wire core_ale,
  input wire core_program_store_strobe,
  input wire host_double_cmd,
  input wire iap_double_cmd,
  output wire irq_valid,
  output wire [15:0] irq_vector,
  output wire [3:0] irq_index,
  output wire [1:0] irq_level,
  output wire [9:0] irq_taken,
  output wire [3:0] in_service,
  output wire idle_request_bit,
  output wire powerdown_request_bit,
  output wire pc_stall,
  output wire clock_run,
  output wire ale_out,
  output wire program_store_strobe,
  output wire brownout_reset_req,
  output wire double_cycle_status,
  output wire mcycle_tick,
  output wire ext_mcycle_tick,
  output wire oscillator_output_pin
);
  `include "ipm_map.vh"

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // highest level first, then lowest index in polling order
  function [6:0] ipm_pick;
    input [9:0] p;
    input [19:0] pr;
    integer l;
    integer i;
    reg hit;
    begin
      ipm_pick = 7'h00;
      hit = 1'b0;
      for (l = 3; l >= 0; l = l - 1)
        for (i = 0; i < `IPM_NSRC; i = i + 1)
          if (!hit && p[i] && (pr[2*i +: 2] == l[1:0]))
          begin
            ipm_pick = {1'b1, l[1:0], i[3:0]};
            hit = 1'b1;
          end
    end
  endfunction

  // vector address of a source index
  function [15:0] ipm_vec;
    input [3:0] idx;
    begin
      case (idx)
        `IPM_IDX_EXT0: ipm_vec = `IPM_VEC_EXT0;
        `IPM_IDX_BO: ipm_vec = `IPM_VEC_BO;
        `IPM_IDX_T0: ipm_vec = `IPM_VEC_T0;
        `IPM_IDX_EXT1: ipm_vec = `IPM_VEC_EXT1;
        `IPM_IDX_T1: ipm_vec = `IPM_VEC_T1;
        `IPM_IDX_CA: ipm_vec = `IPM_VEC_CA;
        `IPM_IDX_EXT2: ipm_vec = `IPM_VEC_EXT2;
        `IPM_IDX_EXT3: ipm_vec = `IPM_VEC_EXT3;
        `IPM_IDX_SER: ipm_vec = `IPM_VEC_SER;
        `IPM_IDX_T2: ipm_vec = `IPM_VEC_T2;
        default: ipm_vec = 16'h0000;
      endcase
    end
  endfunction

  // highest level currently in service
  function [2:0] ipm_top_lvl;
    input [3:0] is;
    begin
      if (is[3])
        ipm_top_lvl = 3'h7;
      else if (is[2])
        ipm_top_lvl = 3'h6;
      else if (is[1])
        ipm_top_lvl = 3'h5;
      else if (is[0])
        ipm_top_lvl = 3'h4;
      else
        ipm_top_lvl = 3'h0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire [2:0] pin_q;
  wire ext0_lvl;
  wire ext1_lvl;
  wire ema_lvl;
  ipm_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({internal_memory_select_pin, ext_int1_n, ext_int0_n}),
    .q(pin_q)
  );
  assign ext0_lvl = pin_q[0];
  assign ext1_lvl = pin_q[1];
  assign ema_lvl = pin_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // state registers

  reg [1:0] ext_prev_reg;
  reg [1:0] edge_flag_reg;
  reg idle_reg;
  reg pd_reg;
  reg [1:0] wake_low_reg;
  reg [3:0] in_service_reg;
  reg irq_valid_reg;
  reg [15:0] irq_vector_reg;
  reg [3:0] irq_index_reg;
  reg [1:0] irq_level_reg;
  reg [9:0] irq_taken_reg;
  reg ale_reg;
  reg program_store_strobe_reg;
  reg bo_reset_reg;
  reg double_reg;

  ////////////////////////////////////////////////////////////////////////////
  // request gathering

  wire [1:0] ext_lvl;
  wire [1:0] ext_fall;
  wire [1:0] ext_req;
  wire [9:0] src_req;
  wire [9:0] src_en;
  wire [9:0] active;
  wire [1:0] pd_wake_low;
  wire wake_ready;
  wire [9:0] wake_mask;
  wire [9:0] pending;
  wire [6:0] pick;
  wire [2:0] top_lvl;
  wire grant;
  wire take;
  wire [9:0] take_mask;
  wire [3:0] lvl_set;
  wire [3:0] lvl_clr;
  wire bo_en;

  assign ext_lvl = {ext1_lvl, ext0_lvl};
  assign ext_fall = ext_prev_reg & ~ext_lvl;
  assign ext_req[0] = ext_edge_sel[0] ? edge_flag_reg[0] : ~ext_lvl[0];
  assign ext_req[1] = ext_edge_sel[1] ? edge_flag_reg[1] : ~ext_lvl[1];
  assign src_req = {timer2_flag, |serial_spi_flags, ext3_flag, ext2_flag, counter_array_flag,
                    timer1_flag, ext_req[1], timer0_flag, brownout_event, ext_req[0]};
  assign bo_en = extended_irq_enable_register[`IPM_IEA_BO_BIT];
  assign src_en = {irq_enable[9:2], bo_en, irq_enable[0]};
  assign active = src_req & src_en & {10{global_enable}};

  // in power-down only an enabled level-mode ext0 or ext1 may respond
  assign pd_wake_low[0] = src_en[`IPM_IDX_EXT0] & global_enable & ~ext_edge_sel[0] & ~ext_lvl[0];
  assign pd_wake_low[1] = src_en[`IPM_IDX_EXT1] & global_enable & ~ext_edge_sel[1] & ~ext_lvl[1];
  // handler is offered only once the pin that woke us is high again
  assign wake_ready = (|wake_low_reg) & ~(|(wake_low_reg & ~ext_lvl));
  assign wake_mask = {6'h00, wake_low_reg[1], 2'h0, wake_low_reg[0]};
  assign pending = pd_reg ? (wake_ready ? wake_mask : 10'h000) : active;

  assign pick = ipm_pick(pending, irq_priority);
  assign top_lvl = ipm_top_lvl(in_service_reg);
  assign grant = pick[6] & (!top_lvl[2] || (pick[5:4] > top_lvl[1:0]));
  assign take = core_ack & irq_valid_reg;
  assign take_mask = take ? (10'h001 << irq_index_reg) : 10'h000;
  assign lvl_set = take ? (4'h1 << irq_level_reg) : 4'h0;
  assign lvl_clr = (core_reti && top_lvl[2]) ? (4'h1 << top_lvl[1:0]) : 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // external edge flags, set wins over clear

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ext_prev_reg <= 2'h3;
      edge_flag_reg <= 2'h0;
    end
    else
    begin
      ext_prev_reg <= ext_lvl;
      edge_flag_reg <= (edge_flag_reg & ~{take_mask[`IPM_IDX_EXT1], take_mask[`IPM_IDX_EXT0]})
                       | (ext_fall & ext_edge_sel & {~pd_reg, ~pd_reg});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power control bits and wake capture

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      idle_reg <= 1'b0;
      pd_reg <= 1'b0;
      wake_low_reg <= 2'h0;
    end
    else
    begin
      if (power_control_wr)
      begin
        idle_reg <= power_control_wdata[`IPM_POWER_CONTROL_REGISTER_IDLE_BIT];
        pd_reg <= power_control_wdata[`IPM_POWER_CONTROL_REGISTER_PD_BIT];
      end
      else if (take)
      begin
        idle_reg <= 1'b0;
        pd_reg <= 1'b0;
      end
      if (!pd_reg || take)
        wake_low_reg <= 2'h0;
      else
        wake_low_reg <= wake_low_reg | pd_wake_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration output and in-service levels

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      in_service_reg <= 4'h0;
      irq_valid_reg <= 1'b0;
      irq_vector_reg <= 16'h0000;
      irq_index_reg <= 4'h0;
      irq_level_reg <= 2'h0;
      irq_taken_reg <= 10'h000;
    end
    else
    begin
      in_service_reg <= (in_service_reg & ~lvl_clr) | lvl_set;
      irq_taken_reg <= take_mask;
      irq_valid_reg <= grant & ~take;
      irq_index_reg <= pick[3:0];
      irq_level_reg <= pick[5:4];
      irq_vector_reg <= ipm_vec(pick[3:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes, brown-out reset and clock doubling

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ale_reg <= 1'b1;
      program_store_strobe_reg <= 1'b1;
      bo_reset_reg <= 1'b0;
      double_reg <= 1'b0;
    end
    else
    begin
      if (pd_reg)
      begin
        ale_reg <= 1'b0;
        program_store_strobe_reg <= 1'b0;
      end
      else if (idle_reg)
      begin
        ale_reg <= 1'b1;
        program_store_strobe_reg <= 1'b1;
      end
      else
      begin
        ale_reg <= core_ale;
        program_store_strobe_reg <= core_program_store_strobe;
      end
      bo_reset_reg <= brownout_event & ~bo_en;
      if (host_double_cmd || iap_double_cmd)
        double_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle dividers

  ipm_mcycle u_mc_int (
    .clk(clk),
    .rst_n(rst_n),
    .run(clock_run),
    .div_sel(double_reg & ema_lvl),
    .tick(mcycle_tick)
  );

  ipm_mcycle u_mc_ext (
    .clk(clk),
    .rst_n(rst_n),
    .run(clock_run),
    .div_sel(1'b0),
    .tick(ext_mcycle_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign clock_run = ~pd_reg | (|wake_low_reg);
  assign oscillator_output_pin = clock_run;
  assign pc_stall = idle_reg | pd_reg;
  assign irq_valid = irq_valid_reg;
  assign irq_vector = irq_vector_reg;
  assign irq_index = irq_index_reg;
  assign irq_level = irq_level_reg;
  assign irq_taken = irq_taken_reg;
  assign in_service = in_service_reg;
  assign idle_request_bit = idle_reg;
  assign powerdown_request_bit = pd_reg;
  assign ale_out = ale_reg;
  assign program_store_strobe = program_store_strobe_reg;
  assign brownout_reset_req = bo_reset_reg;
  assign double_cycle_status = double_reg;
endmodule // ipm_top
`default_nettype wire

//--- tb/interrupt_priority_power_modes_tb.sv
// self-checking bench for the interrupt and power mode controller
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_power_modes_tb;
  logic clk = 1'h0, rst_n = 1'h0, ext_int0_n = 1'h1, ext_int1_n = 1'h1, internal_memory_select_pin = 1'h1;
  logic brownout_event, timer0_flag, timer1_flag, counter_array_flag, ext2_flag, ext3_flag, timer2_flag;
  logic global_enable = 1'h1, power_control_wr = 1'h0, core_reti = 1'h0, host_double_cmd = 1'h0;
  logic iap_double_cmd = 1'h0, take_en = 1'h0, core_ale = 1'h1, core_program_store_strobe = 1'h1, core_ack;
  logic irq_valid, idle_request_bit, powerdown_request_bit, pc_stall, clock_run, ale_out, program_store_strobe;
  logic brownout_reset_req, double_cycle_status, mcycle_tick, ext_mcycle_tick, oscillator_output_pin;
  logic [1:0] ext_edge_sel = 2'h0, irq_level, lag = 2'h0;
  logic [2:0] serial_spi_flags;
  logic [3:0] irq_index, in_service;
  logic [7:0] extended_irq_enable_register = 8'h00, power_control_wdata = 8'h00;
  logic [9:0] irq_enable = 10'h3FF, irq_taken;
  logic [15:0] irq_vector;
  logic [15:0] vt [10] = '{16'h0003,16'h004B,16'h000B,16'h0013,16'h001B,16'h0033,16'h003B,16'h0043,16'h0023,16'h002B};
  logic [19:0] irq_priority = 20'h0;
  logic [31:0] seed = 32'hC51A;
  int failures = 0, samples_checked = 0, n, stack[$];
  ipm_top i_ipm_top (.clk, .rst_n, .ext_int0_n, .ext_int1_n, .internal_memory_select_pin, .ext_edge_sel,
    .brownout_event, .timer0_flag, .timer1_flag, .counter_array_flag, .ext2_flag, .ext3_flag, .serial_spi_flags,
    .timer2_flag, .global_enable, .irq_enable, .extended_irq_enable_register, .irq_priority, .power_control_wr,
    .power_control_wdata, .core_ack, .core_reti, .core_ale, .core_program_store_strobe, .host_double_cmd, .iap_double_cmd,
    .irq_valid, .irq_vector, .irq_index, .irq_level, .irq_taken, .in_service, .idle_request_bit,
    .powerdown_request_bit, .pc_stall, .clock_run, .ale_out, .program_store_strobe, .brownout_reset_req,
    .double_cycle_status, .mcycle_tick, .ext_mcycle_tick, .oscillator_output_pin);
  ipm_core_model i_ipm_core_model (.clk, .rst_n, .irq_valid, .take_en, .lag, .core_ack);
  ////////////////////////////////////////
  initial
    forever #50 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic give_up(input string what);
    failures++;
    $display("Error %s expected event seen none", what);
    complete_run();
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    check(what, {15'h0, exp}, {15'h0, got});
  endtask
  task automatic set_req(input logic [9:0] r);
    {timer2_flag, ext3_flag, ext2_flag, counter_array_flag, timer1_flag, timer0_flag, brownout_event} =
      {r[9], r[7], r[6], r[5], r[4], r[2], r[1]};
    serial_spi_flags = r[8] ? 3'h1 << rnd() % 3 : 3'h0;
  endtask
  function automatic int pick(input logic [9:0] r);
    int best = -1, top = -1;
    foreach (stack[j]) if (stack[j] > top) top = stack[j];
    for (int i = 0; i < 10; i++)
      if (r[i] && global_enable && (i == 1 ? extended_irq_enable_register[3] : irq_enable[i])
          && int'(irq_priority[2*i +: 2]) > top && (best < 0 || irq_priority[2*i +: 2] > irq_priority[2*best +: 2]))
        best = i;
    return best;
  endfunction
  function automatic logic [3:0] ins();
    logic [3:0] v = 4'h0;
    foreach (stack[j]) v[stack[j]] = 1'h1;
    return v;
  endfunction
  task automatic offer(input string what, input int p);
    check_bit(what, p >= 0, irq_valid);
    if (p >= 0)
    begin
      check("vector", vt[p], irq_vector);
      check("index", 16'(p), {12'h0, irq_index});
    end
  endtask
  task automatic take(input int p);
    take_en = 1'h1;
    for (n = 0; n < 20 && irq_taken == 10'h0; n++) tick(1);
    take_en = 1'h0;
    if (n == 20) give_up("taken");
    check("taken", 16'(10'h1 << p), {6'h0, irq_taken});
    stack.push_back(irq_priority[2*p +: 2]);
    check("in_service", {12'h0, ins()}, {12'h0, in_service});
  endtask
  task automatic reti_all();
    int m;
    while (stack.size() > 0)
    begin
      m = 0;
      foreach (stack[j]) if (stack[j] > stack[m]) m = j;
      stack.delete(m);
      core_reti = 1'h1;
      tick(1);
      core_reti = 1'h0;
      tick(1);
      check("in_service", {12'h0, ins()}, {12'h0, in_service});
    end
  endtask
  task automatic pcw(input logic [7:0] d);
    power_control_wdata = d;
    power_control_wr = 1'h1;
    tick(1);
    power_control_wr = 1'h0;
    tick(2);
  endtask
  task automatic gap(input string what, input int exp, input logic osc);
    for (n = 0; n < 30 && (osc ? ext_mcycle_tick : mcycle_tick) !== 1'h1; n++) tick(1);
    if (n == 30) give_up(what);
    tick(1);
    for (n = 1; n < 30 && (osc ? ext_mcycle_tick : mcycle_tick) !== 1'h1; n++) tick(1);
    if (n == 30) give_up(what);
    check(what, 16'(exp), 16'(n));
  endtask
  task automatic arb_round();
    logic [9:0] r;
    int p;
    r = 10'(rnd()) & 10'h3F6;
    irq_enable = 10'(rnd());
    irq_priority = 20'(rnd());
    extended_irq_enable_register = 8'(rnd());
    global_enable = rnd() % 8 != 0;
    lag = 2'(rnd());
    set_req(r);
    tick(3);
    p = pick(r);
    offer("offer", p);
    check_bit("bo reset", r[1] && !extended_irq_enable_register[3], brownout_reset_req);
    if (p >= 0)
    begin
      take(p);
      r[p] = 1'h0;
      set_req(r);
      tick(3);
      offer("preempt", pick(r));
    end
    set_req(10'h0);
    tick(2);
    reti_all();
  endtask
  initial
  begin
    set_req(10'h0);
    tick(12);
    rst_n = 1'h1;
    tick(4);
    repeat (60) arb_round();
    irq_enable = 10'h3FB;
    irq_priority = 20'h0;
    global_enable = 1'h1;
    timer0_flag = 1'h1;
    core_ale = 1'h0;
    core_program_store_strobe = 1'h0;
    pcw(8'h01);
    check_bit("idle", 1'h1, idle_request_bit);
    check_bit("stall", 1'h1, pc_stall);
    check_bit("clock", 1'h1, clock_run);
    check_bit("ale", 1'h1, ale_out);
    check_bit("program_store_strobe", 1'h1, program_store_strobe);
    tick(3);
    check_bit("offer", 1'h0, irq_valid);
    irq_enable = 10'h3FF;
    take(2);
    check_bit("idle", 1'h0, idle_request_bit);
    timer0_flag = 1'h0;
    reti_all();
    irq_enable = 10'h3F7;
    core_ale = 1'h1;
    core_program_store_strobe = 1'h1;
    pcw(8'h02);
    check_bit("pd", 1'h1, powerdown_request_bit);
    check_bit("osc", 1'h0, oscillator_output_pin);
    check_bit("clock", 1'h0, clock_run);
    check_bit("ale", 1'h0, ale_out);
    check_bit("program_store_strobe", 1'h0, program_store_strobe);
    timer0_flag = 1'h1;
    ext_int1_n = 1'h0;
    ext_int0_n = 1'h0;
    ext_edge_sel = 2'h1;
    tick(8);
    check_bit("clock", 1'h0, clock_run);
    check_bit("offer", 1'h0, irq_valid);
    timer0_flag = 1'h0;
    ext_int1_n = 1'h1;
    ext_edge_sel = 2'h0;
    tick(8);
    check_bit("clock", 1'h1, clock_run);
    tick(1024);
    check_bit("offer", 1'h0, irq_valid);
    ext_int0_n = 1'h1;
    for (n = 0; n < 20 && !irq_valid; n++) tick(1);
    if (n == 20) give_up("wake offer");
    check("vector", 16'h0003, irq_vector);
    take(0);
    check_bit("pd", 1'h0, powerdown_request_bit);
    reti_all();
    ext_edge_sel = 2'h1;
    ext_int0_n = 1'h0;
    tick(6);
    ext_int0_n = 1'h1;
    tick(6);
    offer("edge", 0);
    take(0);
    reti_all();
    offer("edge clear", -1);
    check_bit("double", 1'h0, double_cycle_status);
    gap("cycle", 12, 1'h0);
    host_double_cmd = 1'h1;
    tick(1);
    host_double_cmd = 1'h0;
    tick(2);
    check_bit("double", 1'h1, double_cycle_status);
    gap("cycle", 6, 1'h0);
    gap("osc cycle", 12, 1'h1);
    internal_memory_select_pin = 1'h0;
    tick(14);
    gap("cycle", 12, 1'h0);
    pcw(8'h02);
    rst_n = 1'h0;
    tick(2);
    check_bit("pd", 1'h0, powerdown_request_bit);
    check_bit("clock", 1'h1, clock_run);
    check_bit("double", 1'h0, double_cycle_status);
    check_bit("ale", 1'h1, ale_out);
    rst_n = 1'h1;
    tick(4);
    iap_double_cmd = 1'h1;
    tick(1);
    iap_double_cmd = 1'h0;
    tick(2);
    check_bit("double", 1'h1, double_cycle_status);
    complete_run();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    give_up("run");
  end
endmodule // interrupt_priority_power_modes_tb
bind ipm_top ipm_top_chk i_ipm_top_chk (.clk, .rst_n, .irq_priority, .core_ack, .irq_valid, .irq_vector,
  .irq_index, .irq_level, .irq_taken, .in_service, .idle_request_bit, .powerdown_request_bit, .pc_stall,
  .clock_run, .ale_out, .program_store_strobe);
`default_nettype wire

//--- tb/ipm_core_model.sv
// core model that takes offered interrupts after a chosen lag
`timescale 1ns/1ps
`default_nettype none
module ipm_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq_valid,
  input wire logic take_en,
  input wire logic [1:0] lag,
  output logic core_ack
);
  ////////////////////////////////////////
  logic [1:0] wait_reg;
  initial
    core_ack = 1'h0;
  always @(posedge clk)
  begin
    core_ack <= 1'h0;
    wait_reg <= 2'h0;
    if (rst_n && take_en && irq_valid && !core_ack)
    begin
      if (wait_reg == lag)
        core_ack <= 1'h1;
      else
        wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule // ipm_core_model
`default_nettype wire

//--- tb/ipm_top_chk.sv
// assertions for the interrupt and power mode controller
`timescale 1ns/1ps
`default_nettype none
module ipm_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [19:0] irq_priority,
  input wire logic core_ack,
  input wire logic irq_valid,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0] irq_index,
  input wire logic [1:0] irq_level,
  input wire logic [9:0] irq_taken,
  input wire logic [3:0] in_service,
  input wire logic idle_request_bit,
  input wire logic powerdown_request_bit,
  input wire logic pc_stall,
  input wire logic clock_run,
  input wire logic ale_out,
  input wire logic program_store_strobe
);
  ////////////////////////////////////////
  logic [19:0] prio_reg;
  wire [159:0] vtab = {16'h002B,16'h0023,16'h0043,16'h003B,16'h0033,16'h001B,16'h0013,16'h000B,16'h004B,16'h0003};
  wire [2:0] top_is = in_service[3] ? 3'h4 : in_service[2] ? 3'h3 : in_service[1] ? 3'h2 : {2'h0, in_service[0]};
  wire take = irq_valid && core_ack;
  always @(posedge clk)
    prio_reg <= irq_priority;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_level_by_prio: assert property (irq_valid |-> irq_level == prio_reg[irq_index*2 +: 2])
    else $error("offered level differs from source priority");
  chk_vector_map: assert property (irq_valid |-> irq_vector == vtab[irq_index*16 +: 16])
    else $error("offered vector differs from source");
  chk_preempt_level: assert property (irq_valid |-> {1'h0, irq_level} + 3'h1 > top_is)
    else $error("offer not above level in service");
  chk_take_source: assert property (take |=> !irq_valid && irq_taken == 10'h1 << $past(irq_index))
    else $error("taken source differs from offer");
  chk_take_service: assert property (take |=> in_service[$past(irq_level)])
    else $error("taken level not in service");
  chk_take_wake: assert property (take |=> !idle_request_bit && !powerdown_request_bit)
    else $error("service start left a low power bit set");
  chk_idle_stall: assert property ($rose(idle_request_bit) |-> pc_stall && clock_run)
    else $error("idle without stall or with clock stopped");
  chk_idle_strobe: assert property (idle_request_bit && $past(idle_request_bit) |-> ale_out && program_store_strobe)
    else $error("strobes not high in idle");
  chk_pd_strobe: assert property (powerdown_request_bit && $past(powerdown_request_bit) |-> !ale_out && !program_store_strobe)
    else $error("strobes not low in power down");
  chk_pd_stop: assert property ($rose(powerdown_request_bit) |-> !clock_run ##1 !irq_valid)
    else $error("power down left clock or offer running");
  cover property (take && in_service != 4'h0);
  cover property ($fell(idle_request_bit));
  cover property ($fell(powerdown_request_bit));
endmodule // ipm_top_chk
`default_nettype wire
